// ### hw/rxdma_pkg.sv
// Shared constants and types of the receive descriptor DMA engine
package rxdma_pkg;
   // Register byte offsets
   localparam logic [7:0] CMD_OFS = 8'h00;
   localparam logic [7:0] PTR_OFS = 8'h04;
   localparam logic [7:0] CFG_OFS = 8'h08;
   localparam logic [7:0] ISR_OFS = 8'h0c;
   localparam logic [7:0] IMR_OFS = 8'h10;
   localparam logic [7:0] STATE_OFS = 8'h14;
   // Command register bits
   localparam int CMD_EN_BIT = 0;
   localparam int CMD_DIS_BIT = 1;
   // Receive configuration fields and reset value
   localparam int CFG_DRAIN_LSB = 0;
   localparam int CFG_DRAIN_W = 8;
   localparam int CFG_BURST_LSB = 20;
   localparam int CFG_BURST_W = 3;
   localparam logic [31:0] CFG_RESET = 32'h0070_0020;
   localparam logic [31:0] CFG_MASK = 32'h0070_00ff;
   // Interrupt bits
   localparam int IRQ_N = 3;
   localparam int IRQ_HALT = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_PKT = 2;
   // Descriptor layout in host memory
   localparam logic [31:0] LINK_OFS = 32'h0000_0000;
   localparam logic [31:0] CMDSTS_OFS = 32'h0000_0004;
   localparam int LEN_W = 12;
   localparam logic [LEN_W-1:0] DESC_BYTES = 12'h00c;
   localparam logic [LEN_W-1:0] WORD_BYTES = 12'h004;
   localparam logic [LEN_W-1:0] BURST_UNIT = 12'h004;
   // Command/status word fields
   localparam int OWN_BIT = 31;
   localparam int MORE_BIT = 30;
   localparam int OK_BIT = 27;
   localparam int CRC_BIT = 20;
   localparam int FAE_BIT = 19;
   localparam int PKT_CNT_W = 8;

   typedef enum logic [2:0] {
      IDLE_STATE = 3'h0,
      DESCRIPTOR_READ_STATE = 3'h1,
      LINK_REFRESH_STATE = 3'h2,
      FIFO_WAIT_STATE = 3'h3,
      FRAGMENT_WRITE_STATE = 3'h4,
      STATUS_WRITEBACK_STATE = 3'h5,
      ADVANCE_STATE = 3'h6
   } rxdma_state_e;

   typedef enum logic [1:0] {
      KIND_DESC = 2'h0,
      KIND_LINK = 2'h1,
      KIND_FRAG = 2'h2,
      KIND_STAT = 2'h3
   } rxdma_kind_e;

   typedef struct packed {
      rxdma_kind_e kind;
      logic [31:0] addr;
      logic [LEN_W-1:0] len;
      logic [31:0] wdata;
   } rxdma_req_s;

   typedef struct packed {
      logic [31:0] link;
      logic [31:0] cmdsts;
      logic [31:0] bufptr;
   } rxdma_desc_s;

   typedef struct packed {
      logic [PKT_CNT_W-1:0] fifo_packet_count;
      logic [LEN_W-1:0] packet_bytes_in_fifo;
      logic crc_error;
      logic frame_align_error;
   } rxdma_fifo_s;
endpackage

// ### hw/rxdma_irq.sv
// Sticky interrupt status with write-one-to-clear and mask
`timescale 1ns/1ps
module rxdma_irq #(
   parameter int NEV = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [NEV-1:0] event_i,
   input wire logic status_we_i,
   input wire logic mask_we_i,
   input wire logic [NEV-1:0] wdata_i,
   output logic [NEV-1:0] status_o,
   output logic [NEV-1:0] mask_o,
   output logic irq_o
);
   logic [NEV-1:0] status_reg;
   logic [NEV-1:0] status_next;
   logic [NEV-1:0] mask_reg;
   logic [NEV-1:0] mask_next;

   if (NEV < 1) begin : g_chk
      $error("rxdma_irq needs at least one event");
   end

   for (genvar i = 0; i < NEV; i++) begin : g_bit
      always_comb begin
         status_next[i] = status_reg[i];
         if (status_we_i && wdata_i[i]) begin
            status_next[i] = 1'b0;
         end
         // Set wins over a clear in the same cycle
         if (event_i[i]) begin
            status_next[i] = 1'b1;
         end
         mask_next[i] = mask_we_i ? wdata_i[i] : mask_reg[i];
      end
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            status_reg[i] <= 1'b0;
            mask_reg[i] <= 1'b0;
         end else begin
            status_reg[i] <= status_next[i];
            mask_reg[i] <= mask_next[i];
         end
      end
   end

   assign status_o = status_reg;
   assign mask_o = mask_reg;
   assign irq_o = |(status_reg & mask_reg);
endmodule

// ### hw/rxdma_engine.sv
// Receive descriptor DMA engine: descriptor walk, FIFO drain, status write-back
`timescale 1ns/1ps
module rxdma_engine #(
   parameter int BURST_FIELD_MAX = 7
) (
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic [31:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [31:0] REG_RDATA_O,
   output logic REQ_VALID_O,
   output rxdma_pkg::rxdma_req_s REQ_O,
   input wire logic TRANSFER_COMPLETE_I,
   input rxdma_pkg::rxdma_desc_s DESC_I,
   input rxdma_pkg::rxdma_fifo_s FIFO_I,
   input wire logic RECEIVE_OVERFLOW_ERROR_I,
   output logic PKT_DONE_O,
   output logic IRQ_O
);
   localparam int LW = rxdma_pkg::LEN_W;

   if (BURST_FIELD_MAX < 0 || BURST_FIELD_MAX > 7) begin : g_chk
      $error("BURST_FIELD_MAX must lie in 0..7");
   end

   rxdma_pkg::rxdma_state_e state_reg;
   rxdma_pkg::rxdma_state_e state_next;
   logic [31:0] rx_desc_pointer_reg;
   logic [31:0] rx_desc_pointer_next;
   logic rx_desc_done_flag_reg;
   logic rx_desc_done_flag_next;
   logic receive_enable_bit_reg;
   logic receive_enable_bit_next;
   logic [31:0] receive_config_reg;
   logic [31:0] receive_config_next;
   logic [31:0] link_reg;
   logic [31:0] link_next;
   logic [31:0] fragment_pointer_reg;
   logic [31:0] fragment_pointer_next;
   logic [LW-1:0] descriptor_byte_count_reg;
   logic [LW-1:0] descriptor_byte_count_next;
   logic [LW-1:0] written_reg;
   logic [LW-1:0] written_next;
   rxdma_pkg::rxdma_req_s req_reg;
   rxdma_pkg::rxdma_req_s req_next;
   logic pkt_done_reg;
   logic pkt_done_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;

   logic [rxdma_pkg::IRQ_N-1:0] events;
   logic [rxdma_pkg::IRQ_N-1:0] interrupt_status_reg;
   logic [rxdma_pkg::IRQ_N-1:0] irq_mask;
   logic wr_cmd;
   logic wr_ptr;
   logic [rxdma_pkg::CFG_BURST_W-1:0] max_burst_field;
   logic [rxdma_pkg::CFG_DRAIN_W-1:0] drain_level;
   logic [LW-1:0] burst_bytes;
   logic [LW-1:0] desc_len;
   logic [LW-1:0] xfer_len;
   logic [LW-1:0] pkt_bytes;
   logic drain_condition;
   logic final_c;
   logic more_c;
   logic go_frag;
   logic [31:0] final_word;
   logic [31:0] more_word;

   assign wr_cmd = REG_WR_I && (REG_ADDR_I == rxdma_pkg::CMD_OFS);
   assign wr_ptr = REG_WR_I && (REG_ADDR_I == rxdma_pkg::PTR_OFS);
   assign max_burst_field = receive_config_reg[rxdma_pkg::CFG_BURST_LSB +: rxdma_pkg::CFG_BURST_W];
   assign drain_level = receive_config_reg[rxdma_pkg::CFG_DRAIN_LSB +: rxdma_pkg::CFG_DRAIN_W];
   assign burst_bytes = LW'(rxdma_pkg::BURST_UNIT << max_burst_field);
   assign desc_len = (burst_bytes < rxdma_pkg::DESC_BYTES) ? burst_bytes : rxdma_pkg::DESC_BYTES;
   assign pkt_bytes = FIFO_I.packet_bytes_in_fifo;
   assign xfer_len = (pkt_bytes < descriptor_byte_count_reg) ? pkt_bytes : descriptor_byte_count_reg;
   assign drain_condition = (FIFO_I.fifo_packet_count != '0) ||
                            (pkt_bytes > LW'(drain_level));
   assign final_c = (pkt_bytes == '0) && (FIFO_I.fifo_packet_count != '0);
   assign more_c = (descriptor_byte_count_reg == '0) && (pkt_bytes != '0);
   assign go_frag = drain_condition && (pkt_bytes != '0) && (descriptor_byte_count_reg != '0);

   always_comb begin
      final_word = '0;
      final_word[rxdma_pkg::OWN_BIT] = 1'b1;
      final_word[rxdma_pkg::CRC_BIT] = FIFO_I.crc_error;
      final_word[rxdma_pkg::FAE_BIT] = FIFO_I.frame_align_error;
      final_word[rxdma_pkg::OK_BIT] = !FIFO_I.crc_error && !FIFO_I.frame_align_error;
      final_word[LW-1:0] = written_reg;
      more_word = '0;
      more_word[rxdma_pkg::OWN_BIT] = 1'b1;
      more_word[rxdma_pkg::MORE_BIT] = 1'b1;
      more_word[LW-1:0] = written_reg;
   end

   always_comb begin
      state_next = state_reg;
      rx_desc_pointer_next = rx_desc_pointer_reg;
      rx_desc_done_flag_next = rx_desc_done_flag_reg;
      receive_enable_bit_next = receive_enable_bit_reg;
      receive_config_next = receive_config_reg;
      link_next = link_reg;
      fragment_pointer_next = fragment_pointer_reg;
      descriptor_byte_count_next = descriptor_byte_count_reg;
      written_next = written_reg;
      req_next = req_reg;
      pkt_done_next = 1'b0;
      events = '0;
      events[rxdma_pkg::IRQ_OVF] = RECEIVE_OVERFLOW_ERROR_I;
      unique case (state_reg)
         rxdma_pkg::IDLE_STATE: begin
            if (receive_enable_bit_reg && !rx_desc_done_flag_reg) begin
               req_next.kind = rxdma_pkg::KIND_DESC;
               req_next.addr = rx_desc_pointer_reg;
               req_next.len = desc_len;
               req_next.wdata = '0;
               state_next = rxdma_pkg::DESCRIPTOR_READ_STATE;
            end else if (receive_enable_bit_reg) begin
               req_next.kind = rxdma_pkg::KIND_LINK;
               req_next.addr = rx_desc_pointer_reg + rxdma_pkg::LINK_OFS;
               req_next.len = rxdma_pkg::WORD_BYTES;
               req_next.wdata = '0;
               state_next = rxdma_pkg::LINK_REFRESH_STATE;
            end
         end
         rxdma_pkg::LINK_REFRESH_STATE: begin
            if (TRANSFER_COMPLETE_I) begin
               link_next = DESC_I.link;
               state_next = rxdma_pkg::ADVANCE_STATE;
            end
         end
         rxdma_pkg::DESCRIPTOR_READ_STATE: begin
            if (TRANSFER_COMPLETE_I) begin
               link_next = DESC_I.link;
               fragment_pointer_next = DESC_I.bufptr;
               descriptor_byte_count_next = DESC_I.cmdsts[LW-1:0];
               written_next = '0;
               if (DESC_I.cmdsts[rxdma_pkg::OWN_BIT]) begin
                  events[rxdma_pkg::IRQ_HALT] = 1'b1;
                  receive_enable_bit_next = 1'b0;
                  state_next = rxdma_pkg::IDLE_STATE;
               end else begin
                  state_next = rxdma_pkg::FIFO_WAIT_STATE;
               end
            end
         end
         rxdma_pkg::FIFO_WAIT_STATE: begin
            if (final_c) begin
               req_next.kind = rxdma_pkg::KIND_STAT;
               req_next.addr = rx_desc_pointer_reg + rxdma_pkg::CMDSTS_OFS;
               req_next.len = rxdma_pkg::WORD_BYTES;
               req_next.wdata = final_word;
               pkt_done_next = 1'b1;
               events[rxdma_pkg::IRQ_PKT] = 1'b1;
               state_next = rxdma_pkg::STATUS_WRITEBACK_STATE;
            end else if (more_c) begin
               req_next.kind = rxdma_pkg::KIND_STAT;
               req_next.addr = rx_desc_pointer_reg + rxdma_pkg::CMDSTS_OFS;
               req_next.len = rxdma_pkg::WORD_BYTES;
               req_next.wdata = more_word;
               state_next = rxdma_pkg::STATUS_WRITEBACK_STATE;
            end else if (go_frag) begin
               req_next.kind = rxdma_pkg::KIND_FRAG;
               req_next.addr = fragment_pointer_reg;
               req_next.len = xfer_len;
               req_next.wdata = '0;
               descriptor_byte_count_next = descriptor_byte_count_reg - xfer_len;
               fragment_pointer_next = fragment_pointer_reg + 32'(xfer_len);
               written_next = written_reg + xfer_len;
               state_next = rxdma_pkg::FRAGMENT_WRITE_STATE;
            end
         end
         rxdma_pkg::FRAGMENT_WRITE_STATE: begin
            if (TRANSFER_COMPLETE_I) begin
               state_next = rxdma_pkg::FIFO_WAIT_STATE;
            end
         end
         rxdma_pkg::STATUS_WRITEBACK_STATE: begin
            if (TRANSFER_COMPLETE_I) begin
               state_next = rxdma_pkg::ADVANCE_STATE;
            end
         end
         rxdma_pkg::ADVANCE_STATE: begin
            if (link_reg != '0) begin
               rx_desc_pointer_next = link_reg;
               rx_desc_done_flag_next = 1'b0;
               req_next.kind = rxdma_pkg::KIND_DESC;
               req_next.addr = link_reg;
               req_next.len = desc_len;
               req_next.wdata = '0;
               state_next = rxdma_pkg::DESCRIPTOR_READ_STATE;
            end else begin
               rx_desc_done_flag_next = 1'b1;
               events[rxdma_pkg::IRQ_HALT] = 1'b1;
               receive_enable_bit_next = 1'b0;
               state_next = rxdma_pkg::IDLE_STATE;
            end
         end
         default: begin
            state_next = rxdma_pkg::IDLE_STATE;
         end
      endcase
      // Software writes; an enable written in the halt cycle wins
      if (wr_cmd && REG_WDATA_I[rxdma_pkg::CMD_DIS_BIT]) begin
         receive_enable_bit_next = 1'b0;
      end else if (wr_cmd && REG_WDATA_I[rxdma_pkg::CMD_EN_BIT]) begin
         receive_enable_bit_next = 1'b1;
      end
      if (wr_ptr) begin
         rx_desc_pointer_next = REG_WDATA_I;
         rx_desc_done_flag_next = 1'b0;
      end
      if (REG_WR_I && (REG_ADDR_I == rxdma_pkg::CFG_OFS)) begin
         receive_config_next = REG_WDATA_I & rxdma_pkg::CFG_MASK;
      end
   end

   always_comb begin
      rdata_next = '0;
      if (REG_RD_I) begin
         unique case (REG_ADDR_I)
            rxdma_pkg::CMD_OFS: rdata_next[rxdma_pkg::CMD_EN_BIT] = receive_enable_bit_reg;
            rxdma_pkg::PTR_OFS: rdata_next = rx_desc_pointer_reg;
            rxdma_pkg::CFG_OFS: rdata_next = receive_config_reg;
            rxdma_pkg::ISR_OFS: rdata_next[rxdma_pkg::IRQ_N-1:0] = interrupt_status_reg;
            rxdma_pkg::IMR_OFS: rdata_next[rxdma_pkg::IRQ_N-1:0] = irq_mask;
            rxdma_pkg::STATE_OFS: rdata_next[3:0] = {rx_desc_done_flag_reg, state_reg};
            default: rdata_next = '0;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK_I) begin
      if (RST_I) begin
         state_reg <= rxdma_pkg::IDLE_STATE;
         rx_desc_pointer_reg <= '0;
         rx_desc_done_flag_reg <= 1'b0;
         receive_enable_bit_reg <= 1'b0;
         receive_config_reg <= rxdma_pkg::CFG_RESET;
         link_reg <= '0;
         fragment_pointer_reg <= '0;
         descriptor_byte_count_reg <= '0;
         written_reg <= '0;
         req_reg <= '0;
         pkt_done_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         state_reg <= state_next;
         rx_desc_pointer_reg <= rx_desc_pointer_next;
         rx_desc_done_flag_reg <= rx_desc_done_flag_next;
         receive_enable_bit_reg <= receive_enable_bit_next;
         receive_config_reg <= receive_config_next;
         link_reg <= link_next;
         fragment_pointer_reg <= fragment_pointer_next;
         descriptor_byte_count_reg <= descriptor_byte_count_next;
         written_reg <= written_next;
         req_reg <= req_next;
         pkt_done_reg <= pkt_done_next;
         rdata_reg <= rdata_next;
      end
   end

   rxdma_irq #(
      .NEV(rxdma_pkg::IRQ_N)
   ) u_irq (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .event_i(events),
      .status_we_i(REG_WR_I && (REG_ADDR_I == rxdma_pkg::ISR_OFS)),
      .mask_we_i(REG_WR_I && (REG_ADDR_I == rxdma_pkg::IMR_OFS)),
      .wdata_i(REG_WDATA_I[rxdma_pkg::IRQ_N-1:0]),
      .status_o(interrupt_status_reg),
      .mask_o(irq_mask),
      .irq_o(IRQ_O)
   );

   assign REQ_VALID_O = (state_reg == rxdma_pkg::DESCRIPTOR_READ_STATE) ||
                        (state_reg == rxdma_pkg::LINK_REFRESH_STATE) ||
                        (state_reg == rxdma_pkg::FRAGMENT_WRITE_STATE) ||
                        (state_reg == rxdma_pkg::STATUS_WRITEBACK_STATE);
   assign REQ_O = req_reg;
   assign PKT_DONE_O = pkt_done_reg;
   assign REG_RDATA_O = rdata_reg;

   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (RST_I);

   a_idle_desc_read: assert property (
      state_reg == rxdma_pkg::IDLE_STATE && receive_enable_bit_reg && !rx_desc_done_flag_reg
      |=> state_reg == rxdma_pkg::DESCRIPTOR_READ_STATE && REQ_VALID_O &&
          REQ_O.kind == rxdma_pkg::KIND_DESC && REQ_O.addr == $past(rx_desc_pointer_reg))
      else $error("idle did not start descriptor read");
   a_idle_link_refresh: assert property (
      state_reg == rxdma_pkg::IDLE_STATE && receive_enable_bit_reg && rx_desc_done_flag_reg
      |=> state_reg == rxdma_pkg::LINK_REFRESH_STATE && REQ_VALID_O && REQ_O.kind == rxdma_pkg::KIND_LINK &&
          REQ_O.addr == $past(rx_desc_pointer_reg) + rxdma_pkg::LINK_OFS)
      else $error("link refresh request wrong");
   a_refresh_advance: assert property (
      state_reg == rxdma_pkg::LINK_REFRESH_STATE && TRANSFER_COMPLETE_I
      |=> state_reg == rxdma_pkg::ADVANCE_STATE && link_reg == $past(DESC_I.link))
      else $error("link refresh did not advance");
   a_own_halts: assert property (
      state_reg == rxdma_pkg::DESCRIPTOR_READ_STATE && TRANSFER_COMPLETE_I
      |=> (state_reg == rxdma_pkg::IDLE_STATE) == $past(DESC_I.cmdsts[rxdma_pkg::OWN_BIT]) &&
          (state_reg == rxdma_pkg::FIFO_WAIT_STATE) == !$past(DESC_I.cmdsts[rxdma_pkg::OWN_BIT]) &&
          (!$past(DESC_I.cmdsts[rxdma_pkg::OWN_BIT]) || interrupt_status_reg[rxdma_pkg::IRQ_HALT]))
      else $error("ownership check after descriptor read wrong");
   a_frag_length: assert property (
      state_reg == rxdma_pkg::FIFO_WAIT_STATE && !final_c && !more_c && go_frag
      |=> state_reg == rxdma_pkg::FRAGMENT_WRITE_STATE && REQ_O.len == $past(xfer_len) &&
          REQ_O.addr == $past(fragment_pointer_reg) &&
          descriptor_byte_count_reg == $past(descriptor_byte_count_reg) - $past(xfer_len))
      else $error("fragment write length or count wrong");
   a_more_writeback: assert property (
      state_reg == rxdma_pkg::FIFO_WAIT_STATE && !final_c && more_c
      |=> state_reg == rxdma_pkg::STATUS_WRITEBACK_STATE && REQ_O.wdata[rxdma_pkg::OWN_BIT] &&
          REQ_O.wdata[rxdma_pkg::MORE_BIT] && !REQ_O.wdata[rxdma_pkg::CRC_BIT] &&
          !REQ_O.wdata[rxdma_pkg::FAE_BIT])
      else $error("continuation write-back wrong");
   a_final_writeback: assert property (
      state_reg == rxdma_pkg::FIFO_WAIT_STATE && final_c
      |=> REQ_O.wdata[rxdma_pkg::OWN_BIT] && !REQ_O.wdata[rxdma_pkg::MORE_BIT] &&
          REQ_O.wdata[LW-1:0] == $past(written_reg) &&
          REQ_O.wdata[rxdma_pkg::CRC_BIT] == $past(FIFO_I.crc_error) && PKT_DONE_O)
      else $error("final write-back wrong");
   a_advance_link: assert property (
      state_reg == rxdma_pkg::ADVANCE_STATE && link_reg != '0 && !wr_ptr
      |=> rx_desc_pointer_reg == $past(link_reg) && !rx_desc_done_flag_reg &&
          state_reg == rxdma_pkg::DESCRIPTOR_READ_STATE && REQ_O.len == $past(desc_len))
      else $error("advance with link wrong");
   a_advance_null: assert property (
      state_reg == rxdma_pkg::ADVANCE_STATE && link_reg == '0 && !wr_ptr
      |=> state_reg == rxdma_pkg::IDLE_STATE && rx_desc_done_flag_reg &&
          interrupt_status_reg[rxdma_pkg::IRQ_HALT])
      else $error("advance with null link wrong");
   a_overflow_irq: assert property (
      RECEIVE_OVERFLOW_ERROR_I |=> interrupt_status_reg[rxdma_pkg::IRQ_OVF])
      else $error("overflow not flagged");
   a_no_early_drain: assert property (
      state_reg == rxdma_pkg::FIFO_WAIT_STATE && FIFO_I.fifo_packet_count == '0 &&
      pkt_bytes <= LW'(drain_level)
      |=> state_reg != rxdma_pkg::FRAGMENT_WRITE_STATE)
      else $error("drain began below drain level");
   a_ptr_clears_done: assert property (
      wr_ptr |=> !rx_desc_done_flag_reg && rx_desc_pointer_reg == $past(REG_WDATA_I))
      else $error("pointer load did not clear done flag");
endmodule

// ### tb/rxdma_host.sv
// Host memory and receive FIFO model facing the bus-master port
`timescale 1ns/1ps
module rxdma_host (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic valid_i,
   input rxdma_pkg::rxdma_req_s req_i,
   input wire logic pkt_done_i,
   output logic done_o,
   output rxdma_pkg::rxdma_desc_s desc_o,
   output rxdma_pkg::rxdma_fifo_s fifo_o
);
   rxdma_pkg::rxdma_desc_s mem [4];
   rxdma_pkg::rxdma_req_s log [$];
   int wait_n = 0;
   initial done_o = 1'b0;
   initial desc_o = '0;
   // Answers after 0, 1 or 2 idle cycles; descriptor lines show junk otherwise
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      desc_o <= ~desc_o;
      if (rst_i) begin
         wait_n <= 0;
      end else if (valid_i && !done_o) begin
         if (wait_n < log.size() % 3) begin
            wait_n <= wait_n + 1;
         end else begin
            wait_n <= 0;
            done_o <= 1'b1;
            desc_o <= mem[req_i.addr[5:4]];
            log.push_back(req_i);
            if (req_i.kind == rxdma_pkg::KIND_FRAG) begin
               fifo_o.packet_bytes_in_fifo <= fifo_o.packet_bytes_in_fifo - req_i.len;
            end
         end
      end
      if (pkt_done_i) begin
         fifo_o.fifo_packet_count <= fifo_o.fifo_packet_count - 8'h01;
      end
   end
endmodule

// ### tb/tb.sv
// Self-checking bench of the receive descriptor DMA engine
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module tb;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d;} rxdma_row_s;
   logic SYS_CLK_I = 1'b0;
   logic RST_I = 1'b1;
   logic [7:0] REG_ADDR_I = 8'h00;
   logic [31:0] REG_WDATA_I = 32'h0;
   logic REG_WR_I = 1'b0;
   logic REG_RD_I = 1'b0;
   logic RECEIVE_OVERFLOW_ERROR_I = 1'b0;
   logic [31:0] REG_RDATA_O;
   logic REQ_VALID_O, TRANSFER_COMPLETE_I, PKT_DONE_O, IRQ_O;
   rxdma_pkg::rxdma_req_s REQ_O;
   rxdma_pkg::rxdma_desc_s DESC_I;
   rxdma_pkg::rxdma_fifo_s FIFO_I;
   rxdma_pkg::rxdma_req_s ex [6];
   int err_total = 0;
   int checked = 0;
   rxdma_row_s rows [11] = '{'{0, 8'h08, 32'h0070_0020}, '{0, 8'h04, 32'h0}, '{0, 8'h0c, 32'h0},
      '{0, 8'h14, 32'h0}, '{0, 8'h18, 32'h0}, '{1, 8'h08, 32'hffff_ffff}, '{0, 8'h08, 32'h0070_00ff},
      '{1, 8'h08, 32'h0070_0020}, '{1, 8'h04, 32'h10}, '{0, 8'h04, 32'h10}, '{1, 8'h10, 32'h1}};
   always #20 SYS_CLK_I = ~SYS_CLK_I;
   rxdma_engine rxdma_engine_i (.SYS_CLK_I(SYS_CLK_I), .RST_I(RST_I), .REG_ADDR_I(REG_ADDR_I),
      .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I), .REG_RDATA_O(REG_RDATA_O),
      .REQ_VALID_O(REQ_VALID_O), .REQ_O(REQ_O), .TRANSFER_COMPLETE_I(TRANSFER_COMPLETE_I),
      .DESC_I(DESC_I), .FIFO_I(FIFO_I), .RECEIVE_OVERFLOW_ERROR_I(RECEIVE_OVERFLOW_ERROR_I),
      .PKT_DONE_O(PKT_DONE_O), .IRQ_O(IRQ_O));
   rxdma_host rxdma_host_i (.clk_i(SYS_CLK_I), .rst_i(RST_I), .valid_i(REQ_VALID_O), .req_i(REQ_O),
      .pkt_done_i(PKT_DONE_O), .done_o(TRANSFER_COMPLETE_I), .desc_o(DESC_I), .fifo_o(FIFO_I));
   // One register write, or a read compared with the value expected
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK_I);
      REG_ADDR_I <= a;
      REG_WDATA_I <= d;
      REG_WR_I <= w;
      REG_RD_I <= !w;
      @(posedge SYS_CLK_I);
      REG_WR_I <= 1'b0;
      REG_RD_I <= 1'b0;
      #1;
      if (!w) `CHK(REG_RDATA_O, d)
   endtask
   task automatic wait_irq;
      int n = 0;
      while (IRQ_O !== 1'b1 && n < 300) begin
         @(posedge SYS_CLK_I);
         #1;
         n++;
      end
      `CHK(IRQ_O, 1'b1)
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100000;
      err_total++;
      tally_and_finish;
   end
   initial begin
      rxdma_host_i.mem[0] = '{32'h0, 32'h0000_0020, 32'h400};
      rxdma_host_i.mem[1] = '{32'h20, 32'h0000_0020, 32'h100};
      rxdma_host_i.mem[2] = '{32'h0, 32'h0000_0020, 32'h200};
      rxdma_host_i.mem[3] = '{32'h0, 32'h8000_0020, 32'h300};
      rxdma_host_i.fifo_o = '{8'h01, 12'h028, 1'b0, 1'b0};
      ex = '{'{rxdma_pkg::KIND_DESC, 32'h10, 12'h00c, 32'h0}, '{rxdma_pkg::KIND_FRAG, 32'h100, 12'h020, 32'h0},
         '{rxdma_pkg::KIND_STAT, 32'h14, 12'h004, 32'hc000_0020}, '{rxdma_pkg::KIND_DESC, 32'h20, 12'h00c, 32'h0},
         '{rxdma_pkg::KIND_FRAG, 32'h200, 12'h008, 32'h0}, '{rxdma_pkg::KIND_STAT, 32'h24, 12'h004, 32'h8800_0008}};
      repeat (3) @(posedge SYS_CLK_I);
      RST_I <= 1'b0;
      foreach (rows[i]) acc(rows[i].w, rows[i].a, rows[i].d);
      $display("test registers done");
      acc(1, 8'h00, 32'h1);
      wait_irq;
      `CHK(rxdma_host_i.log.size(), 6)
      foreach (ex[i]) begin
         `CHK(rxdma_host_i.log[i].kind, ex[i].kind)
         `CHK(rxdma_host_i.log[i].addr, ex[i].addr)
         `CHK(rxdma_host_i.log[i].len, ex[i].len)
         if (ex[i].kind == rxdma_pkg::KIND_STAT) `CHK(rxdma_host_i.log[i].wdata, ex[i].wdata)
      end
      `CHK(FIFO_I.fifo_packet_count, 8'h00)
      acc(0, 8'h0c, 32'h5);
      acc(0, 8'h14, 32'h8);
      acc(1, 8'h0c, 32'h7);
      acc(0, 8'h0c, 32'h0);
      `CHK(IRQ_O, 1'b0)
      $display("test two descriptor packet done");
      rxdma_host_i.log.delete();
      acc(1, 8'h00, 32'h1);
      wait_irq;
      `CHK(rxdma_host_i.log.size(), 1)
      `CHK(rxdma_host_i.log[0].kind, rxdma_pkg::KIND_LINK)
      `CHK(rxdma_host_i.log[0].addr, 32'h20)
      acc(1, 8'h0c, 32'h7);
      acc(1, 8'h04, 32'h30);
      acc(0, 8'h14, 32'h0);
      $display("test link refresh done");
      rxdma_host_i.log.delete();
      acc(1, 8'h00, 32'h1);
      wait_irq;
      `CHK(rxdma_host_i.log.size(), 1)
      `CHK(rxdma_host_i.log[0].addr, 32'h30)
      acc(0, 8'h00, 32'h0);
      acc(1, 8'h0c, 32'h7);
      $display("test owned descriptor done");
      rxdma_host_i.log.delete();
      rxdma_host_i.fifo_o = '{8'h00, 12'h020, 1'b0, 1'b0};
      acc(1, 8'h04, 32'h0);
      acc(1, 8'h00, 32'h1);
      repeat (20) @(posedge SYS_CLK_I);
      acc(0, 8'h14, 32'h3);
      `CHK(rxdma_host_i.log.size(), 1)
      rxdma_host_i.fifo_o.packet_bytes_in_fifo = 12'h021;
      wait_irq;
      `CHK(rxdma_host_i.log.size(), 3)
      `CHK(rxdma_host_i.log[1].len, 12'h020)
      `CHK(rxdma_host_i.log[1].addr, 32'h400)
      `CHK(rxdma_host_i.log[2].wdata, 32'hc000_0020)
      acc(1, 8'h0c, 32'h7);
      $display("test drain level done");
      @(posedge SYS_CLK_I);
      RECEIVE_OVERFLOW_ERROR_I <= 1'b1;
      @(posedge SYS_CLK_I);
      RECEIVE_OVERFLOW_ERROR_I <= 1'b0;
      acc(0, 8'h0c, 32'h2);
      `CHK(IRQ_O, 1'b0)
      acc(1, 8'h10, 32'h2);
      acc(0, 8'h10, 32'h2);
      `CHK(IRQ_O, 1'b1)
      $display("test overflow done");
      tally_and_finish;
   end
endmodule
